/* File: verilog/acc_control.sv */
// Conversion control: register slave, start sequence, pin sharing and interrupt
// How it works
// - A start bit pulse high then low begins one conversion.
// - While start stays high the converter is reset and done flag is high.
// - The done flag drops to zero when a conversion ends.
// - Conversion end sets interrupt status; interrupt asserts only when unmasked.
// - Divider codes pick undivided, 2, 4, 8, 16 or 32; two codes undefined.
// - Converter powered only while power-down bit is zero.
// - Reference bit picks supply or reference pin, claiming the shared pin.
// - Each set pin-enable bit makes its pin analog, other functions off.
// - Pull-ups drop on pins configured analog.
// - Analog pins override port direction control.
// - Channel code routes one of ten sources to the converter.
// - A conversion takes sixteen converter clock periods.
// - Twelve-bit result read as low and high byte registers.
`include "acc_cfg.svh"
`default_nettype none
module acc_control
   import acc_pkg::*;
#(
   parameter int PIN_N = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [4:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   output logic irq,
   input wire logic cmpIn,
   input wire logic [PIN_N-1:0] pullUpReq,
   input wire logic [PIN_N-1:0] portDirReq,
   output logic [11:0] dacCode,
   output logic convReset,
   output logic convPowerOn,
   output logic [3:0] channelSel,
   output logic refExtSel,
   output logic refPinEn,
   output logic [PIN_N-1:0] analogPinEn,
   output logic [PIN_N-1:0] pullUpEn,
   output logic [PIN_N-1:0] portDir
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      acc_state_t state;
      logic startBit;
      logic [3:0] chan;
      logic powerDown;
      logic refSel;
      logic [2:0] divSel;
      logic [PIN_N-1:0] pinEn;
      logic doneN;
      logic [11:0] result;
      logic irqSts;
      logic irqMsk;
      logic waitReq;
      logic [31:0] readData;
      logic irqOut;
      logic convRst;
      logic powerOn;
      logic [3:0] chanOut;
      logic refOut;
      logic refPin;
      logic [PIN_N-1:0] analogOut;
      logic [PIN_N-1:0] pullUpOut;
      logic [PIN_N-1:0] dirOut;
      logic cmpMeta;
      logic cmpSync;
   } acc_ctl_t;

   acc_ctl_t q;
   acc_ctl_t d;

   logic divTick;
   logic seqDone;
   logic [11:0] seqResult;
   logic seqClear;
   logic req;
   logic accept;
   logic wrLane0;
   logic stsClear;
   logic [31:0] rdMux;

   ////////////////////////////////////////////////////////////////////////////
   // Converter clock and sequencer

   // Both are held cleared outside a running conversion
   assign seqClear = (q.state != ACC_CONV);

   acc_clk_div u_div (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .clear(seqClear),
      .divSel(q.divSel),
      .tick(divTick)
   );

   acc_sar_seq u_seq (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .clear(seqClear),
      .tick(divTick),
      .cmpHigh(q.cmpSync),
      .dacCode(dacCode),
      .done(seqDone),
      .result(seqResult)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake

   assign req = avsRead | avsWrite;
   assign accept = req && !q.waitReq;
   assign wrLane0 = accept && avsWrite && avsByteEnable[0];
   assign stsClear = wrLane0 && (avsAddress == `ACC_OFS_IRQ_STS)
      && avsWriteData[`ACC_IRQ_DONE];

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (avsAddress)
         `ACC_OFS_CTRL: begin
            rdMux[`ACC_CTRL_START] = q.startBit;
            rdMux[`ACC_CTRL_DONE_N] = q.doneN;
            rdMux[`ACC_CTRL_CH] = q.chan;
         end
         `ACC_OFS_CLKPWR: begin
            rdMux[`ACC_CP_FIXED] = `ACC_CP_FIXED_VAL;
            rdMux[`ACC_CP_PD] = q.powerDown;
            rdMux[`ACC_CP_REF] = q.refSel;
            rdMux[`ACC_CP_DIV] = q.divSel;
         end
         `ACC_OFS_PINCFG: begin
            rdMux[PIN_N-1:0] = q.pinEn;
         end
         `ACC_OFS_RES_LO: begin
            rdMux[7:0] = q.result[`ACC_RES_LO_F];
         end
         `ACC_OFS_RES_HI: begin
            rdMux[3:0] = q.result[`ACC_RES_HI_F];
         end
         `ACC_OFS_IRQ_STS: begin
            rdMux[`ACC_IRQ_DONE] = q.irqSts;
         end
         `ACC_OFS_IRQ_MSK: begin
            rdMux[`ACC_IRQ_DONE] = q.irqMsk;
         end
         default: begin
            rdMux = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;

      // Comparator crosses in from the analog side
      d.cmpMeta = cmpIn;
      d.cmpSync = q.cmpMeta;

      // One wait cycle, then one cycle with waitrequest low
      d.waitReq = !(req && q.waitReq);
      if (req && q.waitReq) begin
         d.readData = rdMux;
      end

      // Register writes
      if (wrLane0) begin
         unique case (avsAddress)
            `ACC_OFS_CTRL: begin
               d.startBit = avsWriteData[`ACC_CTRL_START];
               d.chan = avsWriteData[`ACC_CTRL_CH];
            end
            `ACC_OFS_CLKPWR: begin
               d.powerDown = avsWriteData[`ACC_CP_PD];
               d.refSel = avsWriteData[`ACC_CP_REF];
               d.divSel = avsWriteData[`ACC_CP_DIV];
            end
            `ACC_OFS_PINCFG: begin
               d.pinEn = avsWriteData[PIN_N-1:0];
            end
            `ACC_OFS_IRQ_MSK: begin
               d.irqMsk = avsWriteData[`ACC_IRQ_DONE];
            end
            default: begin
               d.startBit = d.startBit;
            end
         endcase
      end

      // Completion: flag low, result captured, status set
      if (q.state == ACC_CONV && seqDone) begin
         d.state = ACC_IDLE;
         d.doneN = 1'b0;
         d.result = seqResult;
      end

      // Start sequence; start high always wins and restarts
      if (d.startBit) begin
         d.state = ACC_ARMED;
         d.doneN = 1'b1;
      end else if (q.state == ACC_ARMED) begin
         d.state = ACC_CONV;
      end

      // Power-down abandons a running conversion without completion
      if (d.powerDown && d.state == ACC_CONV) begin
         d.state = ACC_IDLE;
      end

      // Set wins over a write-one clear in the same cycle
      d.irqSts = (q.irqSts && !stsClear) || (q.state == ACC_CONV && seqDone);

      // Registered outputs
      d.irqOut = d.irqSts && d.irqMsk;
      d.convRst = (d.state == ACC_ARMED) || d.powerDown;
      d.powerOn = !d.powerDown;
      d.chanOut = d.chan;
      d.refOut = d.refSel;
      d.refPin = d.refSel;
      d.analogOut = d.pinEn;
      d.pullUpOut = pullUpReq & ~d.pinEn;
      d.dirOut = portDirReq | d.pinEn;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q.state <= ACC_IDLE;
         q.startBit <= 1'b0;
         q.chan <= `ACC_RST_CH;
         q.powerDown <= `ACC_RST_PD;
         q.refSel <= `ACC_RST_REF;
         q.divSel <= `ACC_RST_DIV;
         q.pinEn <= '0;
         q.doneN <= `ACC_RST_DONE_N;
         q.result <= 12'h000;
         q.irqSts <= 1'b0;
         q.irqMsk <= 1'b0;
         q.waitReq <= 1'b1;
         q.readData <= 32'h0000_0000;
         q.irqOut <= 1'b0;
         q.convRst <= 1'b0;
         q.powerOn <= 1'b1;
         q.chanOut <= `ACC_RST_CH;
         q.refOut <= `ACC_RST_REF;
         q.refPin <= `ACC_RST_REF;
         q.analogOut <= '0;
         q.pullUpOut <= '0;
         q.dirOut <= '0;
         q.cmpMeta <= 1'b0;
         q.cmpSync <= 1'b0;
      end else if (ce) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign avsReadData = q.readData;
   assign avsWaitRequest = q.waitReq;
   assign irq = q.irqOut;
   assign convReset = q.convRst;
   assign convPowerOn = q.powerOn;
   assign channelSel = q.chanOut;
   assign refExtSel = q.refOut;
   assign refPinEn = q.refPin;
   assign analogPinEn = q.analogOut;
   assign pullUpEn = q.pullUpOut;
   assign portDir = q.dirOut;

endmodule : acc_control
`default_nettype wire

/* File: verilog/acc_cfg.svh */
// Constants of the conversion control block: offsets, fields, reset values, divider codes
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define ACC_RES_W 12
`define ACC_STEP_W 4
`define ACC_SAR_LAST 4'hC
`define ACC_CONV_LAST 4'hF

`define ACC_OFS_CTRL 5'h00
`define ACC_OFS_CLKPWR 5'h04
`define ACC_OFS_PINCFG 5'h08
`define ACC_OFS_RES_LO 5'h0C
`define ACC_OFS_RES_HI 5'h10
`define ACC_OFS_IRQ_STS 5'h14
`define ACC_OFS_IRQ_MSK 5'h18

`define ACC_CTRL_START 7
`define ACC_CTRL_DONE_N 6
`define ACC_CTRL_CH 3:0
`define ACC_CP_FIXED 7
`define ACC_CP_PD 6
`define ACC_CP_REF 5
`define ACC_CP_DIV 2:0
`define ACC_IRQ_DONE 0
`define ACC_RES_LO_F 7:0
`define ACC_RES_HI_F 11:8

`define ACC_RST_PD 1'b0
`define ACC_RST_REF 1'b0
`define ACC_RST_DIV 3'h0
`define ACC_RST_CH 4'h0
`define ACC_RST_PIN 8'h00
`define ACC_RST_DONE_N 1'b0
`define ACC_CP_FIXED_VAL 1'b1

`define ACC_DIV_1 3'h4
`define ACC_DIV_2 3'h0
`define ACC_DIV_4 3'h5
`define ACC_DIV_8 3'h1
`define ACC_DIV_16 3'h6
`define ACC_DIV_32 3'h2
`define ACC_DIV_CNT_W 5
`define ACC_LIM_1 5'h00
`define ACC_LIM_2 5'h01
`define ACC_LIM_4 5'h03
`define ACC_LIM_8 5'h07
`define ACC_LIM_16 5'h0F
`define ACC_LIM_32 5'h1F

`endif

/* File: verilog/acc_pkg.sv */
// Types shared by the conversion control block
`default_nettype none
package acc_pkg;

   typedef enum logic [1:0] {
      ACC_IDLE = 2'h0,
      ACC_ARMED = 2'h1,
      ACC_CONV = 2'h3
   } acc_state_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } acc_div_t;

   typedef struct packed {
      logic [3:0] step;
      logic [11:0] sar;
      logic [11:0] res;
      logic done;
      logic fin;
   } acc_seq_t;

endpackage : acc_pkg
`default_nettype wire

/* File: verilog/acc_clk_div.sv */
// Converter clock divider: one tick per converter clock period
`include "acc_cfg.svh"
`default_nettype none
module acc_clk_div
   import acc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic [2:0] divSel,
   output logic tick
);
   acc_div_t q;
   acc_div_t d;
   logic [`ACC_DIV_CNT_W-1:0] lim;
   logic valid;

   always_comb begin
      valid = 1'b1;
      lim = `ACC_LIM_1;
      unique case (divSel)
         `ACC_DIV_1: lim = `ACC_LIM_1;
         `ACC_DIV_2: lim = `ACC_LIM_2;
         `ACC_DIV_4: lim = `ACC_LIM_4;
         `ACC_DIV_8: lim = `ACC_LIM_8;
         `ACC_DIV_16: lim = `ACC_LIM_16;
         `ACC_DIV_32: lim = `ACC_LIM_32;
         default: valid = 1'b0;
      endcase
      d = q;
      d.tick = 1'b0;
      if (clear || !valid) begin
         d.cnt = 5'h00;
      end else if (q.cnt == lim) begin
         d.cnt = 5'h00;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 5'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule : acc_clk_div
`default_nettype wire

/* File: verilog/acc_sar_seq.sv */
// Successive approximation sequencer: sixteen converter clock periods per result
`include "acc_cfg.svh"
`default_nettype none
module acc_sar_seq
   import acc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic tick,
   input wire logic cmpHigh,
   output logic [11:0] dacCode,
   output logic done,
   output logic [11:0] result
);
   acc_seq_t q;
   acc_seq_t d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (clear) begin
         d.step = 4'h0;
         d.sar = 12'h000;
         d.fin = 1'b0;
      end else if (tick && !q.fin) begin
         if (q.step != 4'h0 && q.step <= `ACC_SAR_LAST && !cmpHigh) begin
            d.sar[`ACC_SAR_LAST - q.step] = 1'b0;
         end
         if (q.step < `ACC_SAR_LAST) begin
            d.sar[`ACC_SAR_LAST - 4'h1 - q.step] = 1'b1;
         end
         if (q.step == `ACC_CONV_LAST) begin
            d.done = 1'b1;
            d.fin = 1'b1;
            d.res = d.sar;
         end else begin
            d.step = q.step + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign dacCode = q.sar;
   assign done = q.done;
   assign result = q.res;
endmodule : acc_sar_seq
`default_nettype wire

/* File: verification/acc_control_props.sv */
// Port checker of the conversion control block
`include "acc_cfg.svh"
`default_nettype none
module acc_control_props
   import acc_pkg::*;
#(
   parameter int PIN_N = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic avsWaitRequest,
   input wire logic [4:0] avsAddress,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   input wire logic [PIN_N-1:0] pullUpReq,
   input wire logic [PIN_N-1:0] portDirReq,
   input wire logic [PIN_N-1:0] analogPinEn,
   input wire logic [PIN_N-1:0] pullUpEn,
   input wire logic [PIN_N-1:0] portDir,
   input wire logic convReset,
   input wire logic convPowerOn,
   input wire logic [3:0] channelSel,
   input wire logic refExtSel,
   input wire logic refPinEn
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_pullup_drop: assert property (!$past(rst) && $past(ce)
      |-> pullUpEn == ($past(pullUpReq) & ~analogPinEn)) else $error("pull-up not dropped");
   a_dir_override: assert property (!$past(rst) && $past(ce)
      |-> portDir == ($past(portDirReq) | analogPinEn)) else $error("direction not forced");
   a_pd_reset: assert property (!convPowerOn |-> convReset)
      else $error("powered-down converter not held");
   a_ref_pin: assert property (refPinEn == refExtSel)
      else $error("reference pin claim differs");
   a_ref_follow: assert property (ce && avsWrite && !avsWaitRequest
      && avsByteEnable[0] && avsAddress == `ACC_OFS_CLKPWR
      |=> refExtSel == $past(avsWriteData[`ACC_CP_REF]))
      else $error("reference select not taken");
   a_wait_one: assert property (!avsWaitRequest |=> avsWaitRequest)
      else $error("waitrequest low too long");
   a_wait_answer: assert property (ce && (avsRead || avsWrite) && avsWaitRequest
      |=> !avsWaitRequest) else $error("request not answered");
   a_wait_cause: assert property (!avsWaitRequest |-> $past(avsRead || avsWrite))
      else $error("answer without request");
   a_pin_hold: assert property (!$past(rst) && !$past(avsWrite)
      |-> $stable(analogPinEn)) else $error("pin enables moved");
   a_chan_hold: assert property (!$past(rst) && !$past(avsWrite)
      |-> $stable(channelSel) && $stable(refExtSel)) else $error("selects moved");
endmodule : acc_control_props

bind acc_control acc_control_props #(.PIN_N(PIN_N)) chk (.mclk, .rst, .ce, .avsRead,
   .avsWrite, .avsWaitRequest, .avsAddress, .avsWriteData, .avsByteEnable, .pullUpReq,
   .portDirReq, .analogPinEn, .pullUpEn, .portDir, .convReset, .convPowerOn, .channelSel,
   .refExtSel, .refPinEn);
`default_nettype wire

/* File: verification/adc_conversion_control_test.sv */
// Self-checking bench of the conversion control block
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nFail++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module adc_conversion_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, ce, avsRead, avsWrite, cmpIn, avsWaitRequest, irq;
   logic convReset, convPowerOn, refExtSel, refPinEn;
   logic [4:0] avsAddress;
   logic [31:0] avsWriteData, avsReadData, q;
   logic [3:0] avsByteEnable, channelSel;
   logic [7:0] pullUpReq, portDirReq, analogPinEn, pullUpEn, portDir, lo;
   logic [11:0] dacCode, vin;
   int nFail, numChecks, cyc, n;
   // Rows: address, write data, byte enables, readback
   logic [24:0] rows[7] = '{{5'h04, 8'h25, 4'hF, 8'hA5}, {5'h08, 8'h3C, 4'hF, 8'h3C},
      {5'h08, 8'hFF, 4'hE, 8'h3C}, {5'h00, 8'h09, 4'hF, 8'h09},
      {5'h1C, 8'hFF, 4'hF, 8'h00}, {5'h0C, 8'hFF, 4'hF, 8'h00},
      {5'h18, 8'h01, 4'hF, 8'h01}};
   logic [2:0] codes[6] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
   logic [2:0] bad[2] = '{3'h3, 3'h7};

   acc_control #(.PIN_N(8)) uut (.mclk, .rst, .ce, .avsAddress, .avsRead, .avsWrite,
      .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .irq, .cmpIn,
      .pullUpReq, .portDirReq, .dacCode, .convReset, .convPowerOn, .channelSel,
      .refExtSel, .refPinEn, .analogPinEn, .pullUpEn, .portDir);

   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end

   // Ideal comparator of the analog input
   always @(posedge mclk) cmpIn <= (vin >= dacCode);

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         nFail++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (nFail == 0 && numChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= w;
      avsRead <= !w;
      do @(posedge mclk); while (avsWaitRequest !== 1'b0);
      q = avsReadData;
      avsWrite <= 0;
      avsRead <= 0;
      @(posedge mclk);
   endtask : bus

   task automatic start_conv();
      bus(1, 5'h00, 32'h83);
      bus(1, 5'h00, 32'h03);
   endtask : start_conv

   task automatic get_result();
      bus(0, 5'h0C, 0);
      lo = q[7:0];
      bus(0, 5'h10, 0);
   endtask : get_result

   task automatic conv(input logic [2:0] dv, input int div);
      bus(1, 5'h04, {29'h0, dv});
      bus(1, 5'h00, 32'h83);
      bus(0, 5'h00, 0);
      `CHK(q[7:6], 2'h3)
      `CHK(convReset, 1'b1)
      bus(1, 5'h00, 32'h03);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      `CHK(n >= 16 * div && n <= 16 * div + 8, 1'b1)
      bus(0, 5'h00, 0);
      `CHK(q[7:0], 8'h03)
      get_result();
      if (div >= 4) `CHK({q[3:0], lo}, vin)
      bus(1, 5'h14, 1);
      bus(0, 5'h14, 0);
      `CHK(irq, 1'b0)
   endtask : conv

   initial begin
      logic [4:0] a;
      logic [7:0] d, e;
      logic [3:0] be;
      {rst, ce, avsRead, avsWrite, avsAddress, avsWriteData, cyc} = '0;
      {nFail, numChecks, vin} = '0;
      rst = 1;
      ce = 1;
      avsByteEnable = 4'hF;
      pullUpReq = 8'hFF;
      portDirReq = 8'h00;
      repeat (12) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      foreach (rows[i]) begin
         {a, d, be, e} = rows[i];
         avsByteEnable <= be;
         bus(1, a, {24'h0, d});
         avsByteEnable <= 4'hF;
         bus(0, a, 0);
         `CHK(q[7:0], e)
      end
      `CHK(channelSel, 4'h9)
      `CHK(refPinEn, 1'b1)
      `CHK(analogPinEn, 8'h3C)
      `CHK(pullUpEn, 8'hC3)
      `CHK(portDir, 8'h3C)
      foreach (codes[i]) begin
         vin = 12'hFFF - 12'h31F * i;
         conv(codes[i], 1 << i);
      end
      ////////////////////////////////////////////////////////////////
      bus(1, 5'h18, 0);
      bus(1, 5'h04, 5);
      vin = 12'hFFF;
      start_conv();
      repeat (100) @(posedge mclk);
      `CHK(irq, 1'b0)
      bus(0, 5'h14, 0);
      `CHK(q[0], 1'b1)
      bus(1, 5'h18, 1);
      vin = 12'h000;
      get_result();
      `CHK(irq, 1'b1)
      start_conv();
      repeat (20) @(posedge mclk);
      get_result();
      `CHK({q[3:0], lo}, 12'hFFF)
      repeat (80) @(posedge mclk);
      get_result();
      `CHK({q[3:0], lo}, 12'h000)
      bus(1, 5'h14, 1);
      foreach (bad[i]) begin
         bus(1, 5'h04, {29'h0, bad[i]});
         start_conv();
         repeat (200) @(posedge mclk);
         bus(0, 5'h00, 0);
         `CHK(q[6], 1'b1)
         `CHK(irq, 1'b0)
      end
      ////////////////////////////////////////////////////////////////
      bus(1, 5'h04, 5);
      start_conv();
      repeat (20) @(posedge mclk);
      bus(1, 5'h04, 32'h45);
      @(posedge mclk);
      `CHK(convPowerOn, 1'b0)
      `CHK(convReset, 1'b1)
      repeat (100) @(posedge mclk);
      `CHK(irq, 1'b0)
      bus(1, 5'h04, 5);
      @(posedge mclk);
      `CHK(convPowerOn, 1'b1)
      vin = 12'h5A5;
      repeat (40) @(posedge mclk);
      start_conv();
      ce <= 0;
      repeat (100) @(posedge mclk);
      `CHK(irq, 1'b0)
      ce <= 1;
      repeat (80) @(posedge mclk);
      `CHK(irq, 1'b1)
      get_result();
      `CHK({q[3:0], lo}, 12'h5A5)
      bus(1, 5'h14, 1);
      bus(1, 5'h04, 32'h45);
      @(posedge mclk);
      `CHK(convPowerOn, 1'b0)
      rst <= 1;
      repeat (12) @(posedge mclk);
      `CHK(analogPinEn, 8'h00)
      `CHK(convPowerOn, 1'b1)
      rst <= 0;
      @(posedge mclk);
      bus(0, 5'h04, 0);
      `CHK(q[7:0], 8'h80)
      finish_test();
   end
endmodule : adc_conversion_control_test
`default_nettype wire
